// file: bsr_pkg.sv
`default_nettype none
package bsr_pkg;
  // Clock and time base
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYC = CLK_HZ / MS_PER_S;
  localparam int BOOT_QUIET_MS = 3000;
  localparam int HOST_RST_MS = 1500;
  localparam int FAN_STAGGER_MS = 500;
  localparam int MS_W = 16;

  // Display and glyph geometry, fan count, settings width
  localparam int ROW_CHARS = 16;
  localparam int ROWS = 2;
  localparam int CHARS = ROW_CHARS * ROWS;
  localparam int GLYPHS = 8;
  localparam int GLYPH_ROWS = 8;
  localparam int GLYPH_BYTES = GLYPHS * GLYPH_ROWS;
  localparam int N_FANS = 4;
  localparam int SET_W = 64;

  // Packet layout
  localparam int MAX_LEN = 18;
  localparam int PAY_W = MAX_LEN * 8;
  localparam logic [1:0] CLASS_CMD = 2'h0;
  localparam logic [1:0] CLASS_RSP = 2'h1;
  localparam logic [1:0] CLASS_ERR = 2'h3;

  // Command codes and payload lengths
  localparam logic [5:0] CMD_SAVE = 6'h04;
  localparam logic [5:0] CMD_REBOOT = 6'h05;
  localparam logic [5:0] CMD_CLEAR = 6'h06;
  localparam logic [5:0] CMD_LINE1 = 6'h07;
  localparam logic [5:0] CMD_LINE2 = 6'h08;
  localparam logic [5:0] CMD_GLYPH = 6'h09;
  localparam logic [4:0] LEN_EMPTY = 5'h00;
  localparam logic [4:0] LEN_REBOOT = 5'h03;
  localparam logic [4:0] LEN_LINE = 5'h10;
  localparam logic [4:0] LEN_GLYPH = 5'h09;

  // Reboot-command key patterns
  localparam logic [23:0] KEY_REBOOT = {8'h08, 8'h12, 8'h63};
  localparam logic [23:0] KEY_HOSTRST = {8'h0c, 8'h1c, 8'h61};
  localparam logic [23:0] KEY_POWER = {8'h03, 8'h0b, 8'h5f};

  // Data values
  localparam logic [7:0] CHAR_SPACE = 8'h20;
  localparam logic [7:0] GLYPH_MASK = 8'h3f;
  localparam logic [2:0] SLOT_MAX = 3'h7;
  localparam logic [SET_W-1:0] SET_DEF = 64'h0;

  // Register port
  localparam logic [3:0] REG_ATX_PULSE = 4'h0;
  localparam logic [3:0] REG_REPORT_EN = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam logic [MS_W-1:0] ATX_PULSE_DEF = 16'h00fa;
  localparam logic [3:0] REPORT_EN_DEF = 4'h0;

  typedef enum logic [4:0] {
    ST_LOAD = 5'h01,
    ST_BOOT = 5'h02,
    ST_IDLE = 5'h04,
    ST_HRST = 5'h08,
    ST_PWR = 5'h10
  } bsr_state_type;

  function automatic logic [7:0] pay_byte(input logic [PAY_W-1:0] d, input int i);
    return d[i*8 +: 8];
  endfunction
endpackage
`default_nettype wire

// file: bsr_nv_if.sv
`timescale 1ns/100ps
`default_nettype none
interface bsr_nv_if;
  import bsr_pkg::*;
  logic save;
  logic [7:0] live_chars [CHARS];
  logic [7:0] live_glyph [GLYPH_BYTES];
  logic [4:0] live_cursor;
  logic [SET_W-1:0] live_set;
  logic [7:0] img_chars [CHARS];
  logic [7:0] img_glyph [GLYPH_BYTES];
  logic [4:0] img_cursor;
  logic [SET_W-1:0] img_set;
  modport host(output save, live_chars, live_glyph, live_cursor, live_set,
               input img_chars, img_glyph, img_cursor, img_set);
  modport store(input save, live_chars, live_glyph, live_cursor, live_set,
                output img_chars, img_glyph, img_cursor, img_set);
endinterface
`default_nettype wire

// file: bsr_nvstore.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_nvstore (
  // Clock and power-on reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Boot image
  bsr_nv_if.store nv
);
  import bsr_pkg::*;

  // Only power-on reset restores the factory image; self reboots keep it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < CHARS; i++) begin
        nv.img_chars[i] <= CHAR_SPACE;
      end
      for (int i = 0; i < GLYPH_BYTES; i++) begin
        nv.img_glyph[i] <= 8'h00;
      end
      nv.img_cursor <= 5'h00;
      nv.img_set <= SET_DEF;
    end else if (nv.save) begin
      nv.img_chars <= nv.live_chars;
      nv.img_glyph <= nv.live_glyph;
      nv.img_cursor <= nv.live_cursor;
      nv.img_set <= nv.live_set;
    end
  end
endmodule
`default_nettype wire

// file: bsr_top.sv
// Overview of operation
// - Boot restores saved image before taking commands
// - Save command stores display, glyphs, cursor, settings
// - Reporting, fail-safe, watchdog enables never saved
// - Acknowledge type is 0x40 ORed with code
// - Reboot key acknowledged, then full restart
// - Commands ignored during boot quiet period
// - Host-reset key acknowledged, drives reset, reboots
// - Host reset lasts 1.5 s before reboot
// - Power key pulses power line, then reboots
// - All three keys answer type 0x45
// - Fans powered up staggered during boot
// - Clear fills spaces, cursor to home
// - Top-line write needs 16 bytes
// - Bottom-line write needs 16 bytes
// - Glyph write selects slot, replaces rows
// - Glyph rows six bits, top row first
// - Top type bits give packet class
// - Every command taken while idle answered well within 250 ms
// - Packets failing CRC are dropped unanswered
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module bsr_top #(
  parameter int MS_CYC = bsr_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command packets from the framer
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_type_i,
  input wire logic [4:0] cmd_len_i,
  input wire logic [bsr_pkg::PAY_W-1:0] cmd_data_i,
  input wire logic cmd_crc_ok_i,
  // Responses to the transmitter
  output logic rsp_valid_o,
  output logic [7:0] rsp_type_o,
  output logic [4:0] rsp_len_o,
  // Display content
  output logic [7:0] disp_char_memory_o [bsr_pkg::CHARS],
  output logic [7:0] glyph_pattern_memory_o [bsr_pkg::GLYPH_BYTES],
  output logic [3:0] cursor_col_o,
  output logic cursor_row_o,
  // Settings held by other blocks
  input wire logic [bsr_pkg::SET_W-1:0] settings_i,
  output logic [bsr_pkg::SET_W-1:0] settings_o,
  output logic settings_load_o,
  // Fans, host control, reporting enables
  output logic [bsr_pkg::N_FANS-1:0] fan_pwr_en_o,
  output logic host_reset_o,
  output logic host_power_o,
  output logic [3:0] report_en_o,
  output logic ready_o,
  // Register port
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);
  import bsr_pkg::*;

  bsr_state_type state;
  bsr_state_type next_state;
  logic [31:0] pre_cnt;
  logic ms_tick;
  logic [MS_W-1:0] ms_cnt;
  logic [MS_W-1:0] atx_pulse_ms;
  logic [5:0] code;
  logic [23:0] key;
  logic [2:0] slot;
  logic take;
  logic len_ok;
  logic key_reboot;
  logic key_hostrst;
  logic key_power;
  logic cmd_ok;
  logic do_cmd;

  bsr_nv_if nv ();

  bsr_nvstore u_nvstore (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .nv(nv)
  );

  function automatic logic [4:0] expected_len(input logic [5:0] c);
    unique case (c)
      CMD_REBOOT: expected_len = LEN_REBOOT;
      CMD_LINE1, CMD_LINE2: expected_len = LEN_LINE;
      CMD_GLYPH: expected_len = LEN_GLYPH;
      default: expected_len = LEN_EMPTY;
    endcase
  endfunction

  function automatic logic in_group(input logic [5:0] c);
    return (c >= CMD_SAVE) && (c <= CMD_GLYPH);
  endfunction

  // Command decode
  assign code = cmd_type_i[5:0];
  assign key = {pay_byte(cmd_data_i, 0), pay_byte(cmd_data_i, 1), pay_byte(cmd_data_i, 2)};
  assign slot = cmd_data_i[2:0];
  // Only host-class packets of this group, after a good CRC, while idle
  assign take = cmd_valid_i && cmd_crc_ok_i && (state == ST_IDLE)
    && (cmd_type_i[7:6] == CLASS_CMD) && in_group(code);
  assign len_ok = (cmd_len_i == expected_len(code));
  assign key_reboot = (key == KEY_REBOOT);
  assign key_hostrst = (key == KEY_HOSTRST);
  assign key_power = (key == KEY_POWER);
  always_comb begin
    cmd_ok = len_ok;
    if (code == CMD_REBOOT) begin
      cmd_ok = len_ok && (key_reboot || key_hostrst || key_power);
    end else if (code == CMD_GLYPH) begin
      cmd_ok = len_ok && (pay_byte(cmd_data_i, 0) <= {5'h00, SLOT_MAX});
    end
  end
  assign do_cmd = take && cmd_ok;

  // Millisecond time base
  assign ms_tick = (pre_cnt == 32'(MS_CYC - 1));
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt <= 32'h0;
    end else if (ms_tick || (next_state != state)) begin
      pre_cnt <= 32'h0;
    end else begin
      pre_cnt <= pre_cnt + 32'h1;
    end
  end

  // Milliseconds spent in the current state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ms_cnt <= '0;
    end else if (next_state != state) begin
      ms_cnt <= '0;
    end else if (ms_tick && (ms_cnt != '1)) begin
      ms_cnt <= ms_cnt + 16'h1;
    end
  end

  // Sequencer
  always_comb begin
    next_state = state;
    unique case (state)
      ST_LOAD: begin
        next_state = ST_BOOT;
      end
      ST_BOOT: begin
        if (ms_cnt == 16'(BOOT_QUIET_MS)) begin
          next_state = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (do_cmd && (code == CMD_REBOOT)) begin
          if (key_reboot) begin
            next_state = ST_LOAD;
          end else if (key_hostrst) begin
            next_state = ST_HRST;
          end else begin
            next_state = ST_PWR;
          end
        end
      end
      ST_HRST: begin
        if (ms_cnt == 16'(HOST_RST_MS)) begin
          next_state = ST_LOAD;
        end
      end
      ST_PWR: begin
        // Zero pulse length still reboots after one ms
        if ((ms_cnt >= atx_pulse_ms) && ms_tick) begin
          next_state = ST_LOAD;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= ST_LOAD;
    end else begin
      state <= next_state;
    end
  end

  // Acknowledge one cycle after the packet is taken
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_type_o <= 8'h00;
      rsp_len_o <= 5'h00;
    end else begin
      rsp_valid_o <= take;
      if (take) begin
        rsp_type_o <= {(cmd_ok ? CLASS_RSP : CLASS_ERR), code};
        rsp_len_o <= LEN_EMPTY;
      end
    end
  end

  // Character memory
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < CHARS; i++) begin
        disp_char_memory_o[i] <= CHAR_SPACE;
      end
    end else if (state == ST_LOAD) begin
      disp_char_memory_o <= nv.img_chars;
    end else if (do_cmd) begin
      if (code == CMD_CLEAR) begin
        for (int i = 0; i < CHARS; i++) begin
          disp_char_memory_o[i] <= CHAR_SPACE;
        end
      end else if (code == CMD_LINE1) begin
        for (int i = 0; i < ROW_CHARS; i++) begin
          disp_char_memory_o[i] <= pay_byte(cmd_data_i, i);
        end
      end else if (code == CMD_LINE2) begin
        for (int i = 0; i < ROW_CHARS; i++) begin
          disp_char_memory_o[ROW_CHARS + i] <= pay_byte(cmd_data_i, i);
        end
      end
    end
  end

  // Glyph memory, slot-major, row 0 at the top of the cell
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < GLYPH_BYTES; i++) begin
        glyph_pattern_memory_o[i] <= 8'h00;
      end
    end else if (state == ST_LOAD) begin
      glyph_pattern_memory_o <= nv.img_glyph;
    end else if (do_cmd && (code == CMD_GLYPH)) begin
      for (int r = 0; r < GLYPH_ROWS; r++) begin
        // Bit 5 is the left pixel; upper bits cannot reach the cell
        glyph_pattern_memory_o[slot * GLYPH_ROWS + r] <=
          pay_byte(cmd_data_i, r + 1) & GLYPH_MASK;
      end
    end
  end

  // Cursor
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cursor_col_o <= 4'h0;
      cursor_row_o <= 1'b0;
    end else if (state == ST_LOAD) begin
      cursor_col_o <= nv.img_cursor[3:0];
      cursor_row_o <= nv.img_cursor[4];
    end else if (do_cmd && (code == CMD_CLEAR)) begin
      cursor_col_o <= 4'h0;
      cursor_row_o <= 1'b0;
    end
  end

  // Settings owned elsewhere are handed back at boot
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      settings_o <= SET_DEF;
      settings_load_o <= 1'b0;
    end else begin
      settings_load_o <= (state == ST_LOAD);
      if (state == ST_LOAD) begin
        settings_o <= nv.img_set;
      end
    end
  end

  // Boot image capture
  always_comb begin
    nv.save = do_cmd && (code == CMD_SAVE);
    nv.live_chars = disp_char_memory_o;
    nv.live_glyph = glyph_pattern_memory_o;
    nv.live_cursor = {cursor_row_o, cursor_col_o};
    // Reporting enables are not part of the image
    nv.live_set = settings_i;
  end

  // Fans come on one by one so boot inrush stays low
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fan_pwr_en_o <= '0;
    end else if (state == ST_LOAD) begin
      fan_pwr_en_o <= '0;
    end else if (state == ST_BOOT) begin
      for (int i = 0; i < N_FANS; i++) begin
        if (ms_cnt >= 16'((i + 1) * FAN_STAGGER_MS)) begin
          fan_pwr_en_o[i] <= 1'b1;
        end
      end
    end
  end

  // Host control lines; pins assumed left in their ATX role
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      host_reset_o <= 1'b0;
      host_power_o <= 1'b0;
    end else begin
      host_reset_o <= (next_state == ST_HRST);
      host_power_o <= (next_state == ST_PWR);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_o <= 1'b0;
    end else begin
      ready_o <= (next_state == ST_IDLE);
    end
  end

  // Software registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      atx_pulse_ms <= ATX_PULSE_DEF;
    end else if (reg_wr_i && (reg_addr_i == REG_ATX_PULSE)) begin
      atx_pulse_ms <= reg_wdata_i[MS_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      report_en_o <= REPORT_EN_DEF;
    end else if (state == ST_LOAD) begin
      report_en_o <= REPORT_EN_DEF;
    end else if (reg_wr_i && (reg_addr_i == REG_REPORT_EN)) begin
      report_en_o <= reg_wdata_i[3:0];
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= 32'h0;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        REG_ATX_PULSE: reg_rdata_o <= {16'h0, atx_pulse_ms};
        REG_REPORT_EN: reg_rdata_o <= {28'h0, report_en_o};
        REG_STATUS: reg_rdata_o <= {23'h0, fan_pwr_en_o, state};
        default: reg_rdata_o <= 32'h0;
      endcase
    end else begin
      reg_rdata_o <= 32'h0;
    end
  end
endmodule
`default_nettype wire

// file: bsr_top_props.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_top_props #(
  parameter int MS_CYC = bsr_pkg::MS_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Commands and answers
  input wire logic cmd_valid_i,
  input wire logic [7:0] cmd_type_i,
  input wire logic [4:0] cmd_len_i,
  input wire logic cmd_crc_ok_i,
  input wire logic rsp_valid_o,
  input wire logic [7:0] rsp_type_o,
  input wire logic [4:0] rsp_len_o,
  // Display and control
  input wire logic [7:0] disp_char_memory_o [bsr_pkg::CHARS],
  input wire logic [3:0] cursor_col_o,
  input wire logic cursor_row_o,
  input wire logic settings_load_o,
  input wire logic [bsr_pkg::N_FANS-1:0] fan_pwr_en_o,
  input wire logic host_reset_o,
  input wire logic host_power_o,
  input wire logic ready_o
);
  import bsr_pkg::*;
  localparam int HR_MIN = HOST_RST_MS * MS_CYC - 4;
  localparam int HR_MAX = (HOST_RST_MS + 1) * MS_CYC + 8;
  logic take;
  logic clr;
  int hr_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  assign take = cmd_valid_i && cmd_crc_ok_i && ready_o && cmd_type_i[7:6] == CLASS_CMD
    && cmd_type_i[5:0] >= CMD_SAVE && cmd_type_i[5:0] <= CMD_GLYPH;
  assign clr = take && cmd_type_i[5:0] == CMD_CLEAR;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hr_cnt <= 0;
    end else begin
      hr_cnt <= host_reset_o ? hr_cnt + 1 : 0;
    end
  end
  AST_RSP_NEXT: assert property (take |=> rsp_valid_o && rsp_len_o == 5'h00)
    else $error("accepted command not answered next cycle");
  AST_RSP_CODE: assert property (take |=> rsp_type_o[5:0] == $past(cmd_type_i[5:0])
    && rsp_type_o[7:6] != CLASS_CMD)
    else $error("answer code or class wrong");
  AST_DROP_BAD: assert property (cmd_valid_i && !(cmd_crc_ok_i && ready_o) |=> !rsp_valid_o)
    else $error("answer to dropped packet");
  AST_KEY_BUSY: assert property (rsp_valid_o && rsp_type_o == 8'h45 |-> !ready_o)
    else $error("still ready after key acknowledge");
  AST_HOST_BUSY: assert property (host_reset_o || host_power_o |-> !ready_o)
    else $error("ready while driving host line");
  AST_HRST_LEN: assert property ($fell(host_reset_o) |-> $past(hr_cnt) >= HR_MIN
    && $past(hr_cnt) <= HR_MAX)
    else $error("host reset length wrong");
  AST_CLEAR: assert property (clr && cmd_len_i == LEN_EMPTY |=>
    disp_char_memory_o[0] == CHAR_SPACE && disp_char_memory_o[CHARS-1] == CHAR_SPACE
    && cursor_col_o == 4'h0 && !cursor_row_o)
    else $error("clear left screen or cursor");
  AST_ERR_LEN: assert property (clr && cmd_len_i != LEN_EMPTY |=> rsp_type_o[7:6] == CLASS_ERR)
    else $error("bad length not refused");
  AST_FAN_ORDER: assert property ($changed(fan_pwr_en_o) && fan_pwr_en_o != 4'h0
    |-> fan_pwr_en_o inside {4'h1, 4'h3, 4'h7, 4'hf})
    else $error("fans not powered in order");
  AST_LOAD_QUIET: assert property (settings_load_o |-> !ready_o)
    else $error("image loaded while ready");
  COV_CLEAR: cover property (clr);
  COV_HRST: cover property ($rose(host_reset_o));
  COV_PWR: cover property ($rose(host_power_o));
endmodule
bind bsr_top bsr_top_props #(.MS_CYC(MS_CYC)) i_props (.clk_i, .rst_i, .cmd_valid_i, .cmd_type_i,
  .cmd_len_i, .cmd_crc_ok_i, .rsp_valid_o, .rsp_type_o, .rsp_len_o, .disp_char_memory_o,
  .cursor_col_o, .cursor_row_o, .settings_load_o, .fan_pwr_en_o, .host_reset_o, .host_power_o,
  .ready_o);
`default_nettype wire

// file: bsr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_host_model (
  // Clock
  input wire logic clk_i,
  // Packets to the device
  output logic cmd_valid_o,
  output logic [7:0] cmd_type_o,
  output logic [4:0] cmd_len_o,
  output logic [bsr_pkg::PAY_W-1:0] cmd_data_o,
  output logic cmd_crc_ok_o,
  // Answers
  input wire logic rsp_valid_i,
  input wire logic [7:0] rsp_type_i
);
  import bsr_pkg::*;
  initial begin
    cmd_valid_o = 1'b0;
    cmd_type_o = 8'h00;
    cmd_len_o = 5'h00;
    cmd_data_o = '0;
    cmd_crc_ok_o = 1'b0;
  end
  // One packet, then wait for its answer before the next
  task automatic send(input logic [7:0] t, input logic [4:0] len, input logic [PAY_W-1:0] d,
    input logic ok, output logic got, output logic [7:0] rt);
    got = 1'b0;
    rt = 8'h00;
    @(posedge clk_i);
    cmd_valid_o <= 1'b1;
    // Type driven as given, any class or code; ATX pins are never reassigned
    cmd_type_o <= t;
    cmd_len_o <= len;
    cmd_data_o <= d;
    cmd_crc_ok_o <= ok;
    @(posedge clk_i);
    // Idle bus shows garbage, never the last packet
    cmd_valid_o <= 1'b0;
    cmd_type_o <= ~t;
    cmd_len_o <= ~len;
    cmd_data_o <= ~d;
    cmd_crc_ok_o <= ~ok;
    // Answer pulse stands right after the taking edge
    for (int n = 0; n < 4; n++) begin
      #1;
      if (!got && rsp_valid_i === 1'b1) begin
        got = 1'b1;
        rt = rsp_type_i;
      end
      @(posedge clk_i);
    end
    #1;
  endtask
endmodule
`default_nettype wire

// file: bsr_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_top_tb_top;
  import bsr_pkg::*;
  // Short ms keeps boots near 12000 cycles
  localparam int MS = 4;
  typedef struct {logic [7:0] t; logic [4:0] len; logic [PAY_W-1:0] d;
    logic [7:0] rsp;} bsr_row_type;
  logic clk_i, rst_i, cmd_valid_i, cmd_crc_ok_i, rsp_valid_o, settings_load_o;
  logic host_reset_o, host_power_o, ready_o, cursor_row_o, reg_wr_i, reg_rd_i, got;
  logic [7:0] cmd_type_i, rsp_type_o, rt;
  logic [4:0] cmd_len_i, rsp_len_o;
  logic [PAY_W-1:0] cmd_data_i, g, gb;
  logic [7:0] disp [CHARS];
  logic [7:0] glyph [GLYPH_BYTES];
  logic [3:0] cursor_col_o, report_en_o, reg_addr_i, fan;
  logic [SET_W-1:0] settings_i, settings_o;
  logic [31:0] reg_wdata_i, reg_rdata_o;
  int n_errors, total_checks, cnt;
  bsr_row_type rows [10];
  bsr_top #(.MS_CYC(MS)) i_dut (.clk_i, .rst_i, .cmd_valid_i, .cmd_type_i, .cmd_len_i, .cmd_data_i,
    .cmd_crc_ok_i, .rsp_valid_o, .rsp_type_o, .rsp_len_o, .disp_char_memory_o(disp),
    .glyph_pattern_memory_o(glyph), .cursor_col_o, .cursor_row_o, .settings_i, .settings_o,
    .settings_load_o, .fan_pwr_en_o(fan), .host_reset_o, .host_power_o, .report_en_o, .ready_o,
    .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o);
  bsr_host_model i_host (.clk_i, .cmd_valid_o(cmd_valid_i), .cmd_type_o(cmd_type_i),
    .cmd_len_o(cmd_len_i), .cmd_data_o(cmd_data_i), .cmd_crc_ok_o(cmd_crc_ok_i),
    .rsp_valid_i(rsp_valid_o), .rsp_type_i(rsp_type_o));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [PAY_W-1:0] seq(input logic [7:0] b, input int n);
    logic [PAY_W-1:0] r;
    r = '0;
    for (int i = 0; i < n; i++) r[i*8 +: 8] = b + 8'(i);
    return r;
  endfunction
  task automatic conclude;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] gv, input logic [31:0] e, input string m);
    total_checks++;
    if (gv !== e) begin
      n_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, gv, e);
    end
  endtask
  // Zero expected means no answer at all
  task automatic chk_rsp(input logic [7:0] e, input string m);
    chk({23'h0, got, rt}, e == 8'h00 ? 32'h0 : {23'h0, 1'b1, e}, m);
  endtask
  task automatic cmd(input logic [7:0] t, input logic [4:0] len, input logic [PAY_W-1:0] d);
    i_host.send(t, len, d, 1'b1, got, rt);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] e, input string m);
    @(posedge clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e, m);
  endtask
  task automatic wait_ready;
    for (cnt = 0; cnt < 40000 && ready_o !== 1'b1; cnt++) @(posedge clk_i);
    if (ready_o !== 1'b1) begin
      n_errors++;
      $display("[FAIL] %0t never ready", $time);
      conclude();
    end
  endtask
  task automatic pulse_len(input bit pwr);
    for (cnt = 0; (pwr ? host_power_o : host_reset_o) === 1'b1 && cnt < 20000; cnt++) begin
      @(posedge clk_i);
    end
  endtask
  initial begin
    {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, n_errors, total_checks} = '0;
    rst_i = 1'b1;
    settings_i = 64'h5a;
    g = seq(8'h30, 9);
    g[7:0] = 8'h03;
    gb = seq(8'h08, 9);
    repeat (16) @(posedge clk_i);
    chk(32'(disp[7]), 32'h20, "reset chars");
    chk(32'({rsp_valid_o, ready_o, host_reset_o, host_power_o}), 32'h0, "reset outputs");
    rst_i <= 1'b0;
    rdc(4'h0, 32'd250, "pulse default");
    rdc(4'hc, 32'h0, "unmapped read");
    wait_ready();
    chk(32'(fan), 32'hf, "fans after boot");
    chk(32'(settings_o), 32'h0, "factory settings");
    rdc(4'h8, 32'h1e4, "status idle");
    $display("test reset done");
    rows = '{'{8'h04, 5'd0, '0, 8'h44}, '{8'h06, 5'd0, '0, 8'h46},
      '{8'h07, 5'd16, seq(8'h41, 16), 8'h47}, '{8'h08, 5'd16, seq(8'h61, 16), 8'h48},
      '{8'h09, 5'd9, g, 8'h49}, '{8'h06, 5'd1, '0, 8'hc6}, '{8'h07, 5'd15, seq(8'h30, 15), 8'hc7},
      '{8'h09, 5'd9, gb, 8'hc9}, '{8'h05, 5'd3, PAY_W'(24'h030201), 8'hc5},
      '{8'h04, 5'd1, '0, 8'hc4}};
    foreach (rows[i]) begin
      cmd(rows[i].t, rows[i].len, rows[i].d);
      chk_rsp(rows[i].rsp, "row answer");
    end
    for (int i = 0; i < 16; i++) begin
      chk(32'(disp[i]), 32'(8'h41 + 8'(i)), "top row");
      chk(32'(disp[16+i]), 32'(8'h61 + 8'(i)), "bottom row");
    end
    for (int r = 0; r < 8; r++) chk(32'(glyph[24+r]), 32'(8'h31 + 8'(r)), "glyph row");
    chk(32'(glyph[0]), 32'h0, "slot 0 untouched");
    $display("test table done");
    i_host.send(8'h06, 5'd0, '0, 1'b0, got, rt);
    chk_rsp(8'h00, "bad crc answered");
    cmd(8'h46, 5'd0, '0);
    chk_rsp(8'h00, "response class answered");
    chk(32'(disp[0]), 32'h41, "dropped packet acted");
    $display("test drop done");
    wr(4'h4, 32'hf);
    chk(32'(report_en_o), 32'hf, "enables set");
    cmd(8'h04, 5'd0, '0);
    chk_rsp(8'h44, "save");
    settings_i <= 64'ha5;
    cmd(8'h06, 5'd0, '0);
    chk_rsp(8'h46, "clear");
    chk(32'({disp[20], cursor_col_o, cursor_row_o}), 32'h400, "clear result");
    cmd(8'h05, 5'd3, PAY_W'(24'h631208));
    chk_rsp(8'h45, "reboot");
    chk(32'(ready_o), 32'h0, "busy after reboot");
    cmd(8'h06, 5'd0, '0);
    chk_rsp(8'h00, "answer while booting");
    wait_ready();
    chk(32'({disp[0], disp[31], glyph[31]}), 32'h417038, "restored screen");
    chk(32'(settings_o), 32'h5a, "restored settings");
    chk(32'(report_en_o), 32'h0, "enables not kept");
    $display("test reboot done");
    cmd(8'h05, 5'd3, PAY_W'(24'h611c0c));
    chk_rsp(8'h45, "host reset");
    chk(32'(host_reset_o), 32'h1, "host reset driven");
    pulse_len(1'b0);
    chk(32'(cnt >= 1500 * MS - 8 && cnt <= 1501 * MS + 8), 32'h1, "host reset length");
    wait_ready();
    chk(32'(fan), 32'hf, "fans after reset");
    $display("test host reset done");
    wr(4'h0, 32'd5);
    cmd(8'h05, 5'd3, PAY_W'(24'h5f0b03));
    chk_rsp(8'h45, "power");
    chk(32'(host_power_o), 32'h1, "power driven");
    pulse_len(1'b1);
    chk(32'(cnt >= 5 * MS - 8 && cnt <= 6 * MS + 8), 32'h1, "power length");
    wait_ready();
    $display("test power done");
    conclude();
  end
endmodule
`default_nettype wire
